// [include/rlse_pkg.sv]
// Package of the receive latched event status block: offsets, fields,
// timing figures and the carrier types for framer-side inputs.
// Assumes one 250 MHz system clock and a recovered line clock sampled on it.
//
// Functional notes
// - E1: two bad CAS alignment words latch event.
// - E1: three bad FAS words latch event.
// - Timeslot 16 under three zeros/16 frames latches.
// - Timeslot 16 all zeros over multiframe latches.
// - CRC-4 boundary event, else free 2 ms.
// - Align frame event about every 250 us.
// - Each condition has rising and falling bits.
// - No receive clock edge one channel: clock lost.
// - T1: spare code present condition tracked.
// - T1: loop-up and loop-down conditions tracked.
// - E1: V5.2 link detect and clear bits.
// - E1: distant alarm after two multiframes.
// - Elastic store full latches event.
// - Elastic store empty latches event.
// - Slip latches on repeat or drop.
// - Enabled channel signaling change latches event.
// - One-second event from receive clock.
// - Timer event: 1 s, short interval, manual.
// - All latched bits hold and flag attention.
// - Port registers at documented per-port offsets.
// - Latched bit stays until host reads it.
// - Multiframe event on framer multiframe boundaries.
`default_nettype none
package rlse_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [15:0] RLSE_IDX_RLS3     = 16'h0092;
  localparam logic [15:0] RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS     = 16'h0093;
  localparam logic [15:0] RLSE_IDX_CTRL     = 16'h00F0;
  localparam logic [15:0] RLSE_IDX_SIGEN    = 16'h00F1;
  localparam logic [15:0] RLSE_PORT_STRIDE  = 16'h0200;
  localparam logic [15:0] RLSE_GROUP_STRIDE = 16'h2000;
  localparam int          RLSE_GROUP_PORTS  = 8;
  // Control register fields.
  localparam int RLSE_CTRL_E1      = 0;
  localparam int RLSE_CTRL_CRC4    = 1;
  localparam int RLSE_CTRL_SHORT   = 2;
  localparam int RLSE_CTRL_MANUAL  = 3;
  localparam int RLSE_CTRL_LATCH   = 4;
  localparam logic [7:0] RLSE_CTRL_RESET = 8'h00;
  // T1 view of the shared offset.
  localparam int T1_LOOP_UP_DETECTED = 0, T1_LOOP_DOWN_DETECTED = 1, T1_SPARE_CODE_DETECTED = 2, T1_RECEIVE_CLOCK_LOST_DETECTED = 3;
  localparam int T1_LOOP_UP_CLEARED = 4, T1_LOOP_DOWN_CLEARED = 5, T1_SPARE_CODE_CLEARED = 6, T1_RECEIVE_CLOCK_LOST_CLEARED = 7;
  // E1 view of the shared offset.
  localparam int E1_DMAD = 0, E1_V52D = 1, E1_RECEIVE_CLOCK_LOST_DETECTED = 3;
  localparam int E1_DMAC = 4, E1_V52C = 5, E1_RECEIVE_CLOCK_LOST_CLEARED = 7;
  // Buffer, signaling and timer register.
  localparam int R4_RMF = 0, R4_TIMER = 1, R4_ONE_SECOND_EVENT = 2, R4_SCOS = 3;
  localparam int R4_SLIP = 5, R4_EMPTY = 6, R4_FULL = 7;
  localparam logic [7:0] RLSE_LATCH_RESET = 8'h00;
  // Detection thresholds.
  localparam logic [1:0] RLSE_CAS_ERRS   = 2'd2;
  localparam logic [1:0] RLSE_FAS_ERRS   = 2'd3;
  localparam logic [3:0] RLSE_ONES_FRMS  = 4'd15;
  localparam logic [4:0] RLSE_ONES_ZEROS = 5'd3;
  localparam logic [1:0] RLSE_DMA_MFS    = 2'd2;
  localparam int         RLSE_DMA_BIT    = 2;
  // Timing: clock, line rates and intervals.
  localparam int RLSE_CLK_KHZ   = 250000;
  localparam int RLSE_T1_KHZ    = 1544;
  localparam int RLSE_E1_KHZ    = 2048;
  localparam int RLSE_CHAN_BITS = 8;
  localparam int RLSE_RECEIVE_CLOCK_LOST_T1 = RLSE_CHAN_BITS * RLSE_CLK_KHZ / RLSE_T1_KHZ;
  localparam int RLSE_RECEIVE_CLOCK_LOST_E1 = RLSE_CHAN_BITS * RLSE_CLK_KHZ / RLSE_E1_KHZ;
  localparam int RLSE_AF_US      = 250;
  localparam int RLSE_CRCMF_US   = 2000;
  localparam int RLSE_T1_SHORT_US = 42000;
  localparam int RLSE_E1_SHORT_US = 62500;
  localparam int RLSE_SEC_US      = 1000000;

  typedef struct packed {
    logic        recovered_receive_clock;
    logic        spare_code_present;
    logic        loop_up_present;
    logic        loop_down_present;
    logic        v52_link_present;
    logic        frame;
    logic [7:0]  ts16;
    logic        cas_mf_start;
    logic        cas_word_err;
    logic        cas_word_ok;
    logic        fas_word_err;
    logic        fas_word_ok;
    logic        crc_mf_boundary;
    logic        rx_mf_boundary;
    logic        elastic_full;
    logic        elastic_empty;
    logic [31:0] signaling_change;
  } rlse_rx_in_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [17:0] adr;
    logic [31:0] dat;
  } rlse_wb_req_t;
endpackage
`default_nettype wire

// [rtl/rlse_port.sv]
// Receive latched event status for one framer port, classic Wishbone slave.
// Assumes framer inputs are synchronous to clk_i and strobes last one cycle.
//
// Design decision made here: the Wishbone interface to the registers.
`default_nettype none
module rlse_port
  import rlse_pkg::*;
#(
  parameter int PORT_NUM     = 1,
  parameter int SEC_T1       = RLSE_T1_KHZ * RLSE_SEC_US / 1000,
  parameter int SEC_E1       = RLSE_E1_KHZ * RLSE_SEC_US / 1000,
  parameter int SHORT_T1     = RLSE_T1_KHZ * RLSE_T1_SHORT_US / 1000,
  parameter int SHORT_E1     = RLSE_E1_KHZ * RLSE_E1_SHORT_US / 1000,
  parameter int CRCMF_EDGES  = RLSE_E1_KHZ * RLSE_CRCMF_US / 1000,
  parameter int AF_EDGES_T1  = RLSE_T1_KHZ * RLSE_AF_US / 1000,
  parameter int AF_EDGES_E1  = RLSE_E1_KHZ * RLSE_AF_US / 1000
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire rlse_wb_req_t wb_req_i,
  output var  logic         wb_ack_o,
  output var  logic [31:0]  wb_dat_o,
  input  wire rlse_rx_in_t  rx_i,
  output var  logic         latched_pending_o,
  output var  logic [7:0]   e1_event_o
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] PORT_BASE = 16'((PORT_NUM - 1) * RLSE_PORT_STRIDE
    + ((PORT_NUM - 1) / RLSE_GROUP_PORTS) * RLSE_GROUP_STRIDE);
  localparam logic [10:0] RECEIVE_CLOCK_LOST_T1 = 11'(RLSE_RECEIVE_CLOCK_LOST_T1);
  localparam logic [10:0] RECEIVE_CLOCK_LOST_E1 = 11'(RLSE_RECEIVE_CLOCK_LOST_E1);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  ctrl;
    logic [31:0] sig_en;
    logic [7:0]  t1_r3;
    logic [7:0]  e1_r3;
    logic [7:0]  r4;
    logic [7:0]  e1_r2;
    logic        pend;
    logic        rclk_d;
    logic [10:0] idle_cnt;
    logic        receive_clock_lost;
    logic [3:0]  cond_d;
    logic [1:0]  cas_cnt;
    logic [1:0]  fas_cnt;
    logic [3:0]  frm_cnt;
    logic [4:0]  zero_cnt;
    logic        ts16_or;
    logic        mf_seen;
    logic [1:0]  dma_cnt;
    logic [21:0] sec_cnt;
    logic [21:0] tmr_cnt;
    logic [12:0] mf2_cnt;
    logic [9:0]  af_cnt;
  } rlse_state_t;

  rlse_state_t st_reg, st_next;

  function automatic logic [3:0] zeros8(input logic [7:0] b);
    zeros8 = 4'd0;
    for (int i = 0; i < 8; i++) begin
      zeros8 = zeros8 + {3'd0, ~b[i]};
    end
  endfunction

  function automatic logic hit(input logic [17:0] adr,
                               input logic [15:0] idx);
    hit = (adr[17:2] == PORT_BASE + idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        req;
  logic        e1;
  logic        edge_r;
  logic [3:0]  cond;
  logic [7:0]  t1_set, e1_set, r4_set, e1_r2_set, t1_clr, e1_clr, r4_clr;
  logic        ones_ev, zeros_ev, sec_hit, tmr_hit, mf2_hit, af_hit;
  logic [21:0] tmr_lim;
  logic [4:0]  zero_sum;

  always_comb begin
    st_next  = st_reg;
    e1       = st_reg.ctrl[RLSE_CTRL_E1];
    req      = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;
    edge_r   = rx_i.recovered_receive_clock ^ st_reg.rclk_d;
    t1_set   = 8'h00;
    e1_set   = 8'h00;
    r4_set   = 8'h00;
    e1_r2_set = 8'h00;
    t1_clr   = 8'h00;
    e1_clr   = 8'h00;
    r4_clr   = 8'h00;
    ones_ev  = 1'b0;
    zeros_ev = 1'b0;
    zero_sum = st_reg.zero_cnt + {1'b0, zeros8(rx_i.ts16)};
    st_next.rclk_d = rx_i.recovered_receive_clock;
    st_next.ctrl[RLSE_CTRL_LATCH] = 1'b0;

    // Clock loss: count system cycles with no line clock transition.
    if (edge_r) begin
      st_next.idle_cnt = 11'd0;
      st_next.receive_clock_lost     = 1'b0;
    end else if (st_reg.idle_cnt >= (e1 ? RECEIVE_CLOCK_LOST_E1 : RECEIVE_CLOCK_LOST_T1)) begin
      st_next.receive_clock_lost = 1'b1;
    end else begin
      st_next.idle_cnt = st_reg.idle_cnt + 11'd1;
    end

    // Distant multiframe alarm, judged at each frame 0.
    if (rx_i.frame & rx_i.cas_mf_start) begin
      if (!rx_i.ts16[RLSE_DMA_BIT]) begin
        st_next.dma_cnt = 2'd0;
      end else if (st_reg.dma_cnt != RLSE_DMA_MFS) begin
        st_next.dma_cnt = st_reg.dma_cnt + 2'd1;
      end
    end

    // Conditions: loop-up, loop-down, spare, clock loss / link, alarm.
    cond = e1 ? {st_reg.receive_clock_lost, 1'b0, rx_i.v52_link_present,
                 st_reg.dma_cnt == RLSE_DMA_MFS}
              : {st_reg.receive_clock_lost, rx_i.spare_code_present,
                 rx_i.loop_down_present, rx_i.loop_up_present};
    st_next.cond_d = cond;
    if (e1) begin
      e1_set[3:0] = cond & ~st_reg.cond_d;
      e1_set[7:4] = ~cond & st_reg.cond_d;
      e1_set[2] = 1'b0;
      e1_set[6] = 1'b0;
    end else begin
      t1_set[3:0] = cond & ~st_reg.cond_d;
      t1_set[7:4] = ~cond & st_reg.cond_d;
    end

    // Alignment word error runs; a good word breaks the run.
    if (rx_i.cas_word_ok) begin
      st_next.cas_cnt = 2'd0;
    end else if (rx_i.cas_word_err) begin
      if (st_reg.cas_cnt + 2'd1 == RLSE_CAS_ERRS) begin
        e1_r2_set[5] = e1;
        st_next.cas_cnt = 2'd0;
      end else begin
        st_next.cas_cnt = st_reg.cas_cnt + 2'd1;
      end
    end
    if (rx_i.fas_word_ok) begin
      st_next.fas_cnt = 2'd0;
    end else if (rx_i.fas_word_err) begin
      if (st_reg.fas_cnt + 2'd1 == RLSE_FAS_ERRS) begin
        e1_r2_set[4] = e1;
        st_next.fas_cnt = 2'd0;
      end else begin
        st_next.fas_cnt = st_reg.fas_cnt + 2'd1;
      end
    end

    // Timeslot 16 content checks, independent of signaling mode.
    if (rx_i.frame) begin
      st_next.frm_cnt = st_reg.frm_cnt + 4'd1;
      st_next.zero_cnt = (zero_sum > RLSE_ONES_ZEROS) ? RLSE_ONES_ZEROS
                                                      : zero_sum;
      if (st_reg.frm_cnt == RLSE_ONES_FRMS) begin
        ones_ev = (zero_sum < RLSE_ONES_ZEROS);
        st_next.zero_cnt = 5'd0;
      end
      if (rx_i.cas_mf_start) begin
        zeros_ev = st_reg.mf_seen & ~st_reg.ts16_or;
        st_next.mf_seen = 1'b1;
        st_next.ts16_or = |rx_i.ts16;
      end else begin
        st_next.ts16_or = st_reg.ts16_or | (|rx_i.ts16);
      end
    end
    e1_r2_set[3] = ones_ev;
    e1_r2_set[2] = zeros_ev;

    // Free-running intervals, counted in recovered clock edges.
    tmr_lim = st_reg.ctrl[RLSE_CTRL_SHORT]
              ? 22'(e1 ? SHORT_E1 : SHORT_T1)
              : 22'(e1 ? SEC_E1 : SEC_T1);
    sec_hit = 1'b0;
    tmr_hit = 1'b0;
    mf2_hit = 1'b0;
    af_hit  = 1'b0;
    if (rx_i.recovered_receive_clock & ~st_reg.rclk_d) begin
      sec_hit = st_reg.sec_cnt >= 22'(e1 ? SEC_E1 : SEC_T1) - 22'd1;
      st_next.sec_cnt = sec_hit ? 22'd0 : st_reg.sec_cnt + 22'd1;
      tmr_hit = st_reg.tmr_cnt >= tmr_lim - 22'd1;
      st_next.tmr_cnt = tmr_hit ? 22'd0 : st_reg.tmr_cnt + 22'd1;
      mf2_hit = st_reg.mf2_cnt >= 13'(CRCMF_EDGES) - 13'd1;
      st_next.mf2_cnt = mf2_hit ? 13'd0 : st_reg.mf2_cnt + 13'd1;
      af_hit = st_reg.af_cnt >= 10'(e1 ? AF_EDGES_E1 : AF_EDGES_T1) - 10'd1;
      st_next.af_cnt = af_hit ? 10'd0 : st_reg.af_cnt + 10'd1;
    end
    e1_r2_set[1] = st_reg.ctrl[RLSE_CTRL_CRC4] ? rx_i.crc_mf_boundary
                                                : mf2_hit;
    e1_r2_set[0] = af_hit;

    r4_set[R4_FULL]  = rx_i.elastic_full;
    r4_set[R4_EMPTY] = rx_i.elastic_empty;
    r4_set[R4_SLIP]  = rx_i.elastic_full | rx_i.elastic_empty;
    r4_set[R4_SCOS]  = |(rx_i.signaling_change & st_reg.sig_en);
    r4_set[R4_ONE_SECOND_EVENT]  = sec_hit;
    r4_set[R4_TIMER] = st_reg.ctrl[RLSE_CTRL_MANUAL]
                       ? st_reg.ctrl[RLSE_CTRL_LATCH] : tmr_hit;
    r4_set[R4_RMF]   = rx_i.rx_mf_boundary;

    // Bus slave: one wait state, status register reads clear what they return.
    st_next.ack = req;
    st_next.dat = 32'h0000_0000;
    if (req) begin
      if (hit(wb_req_i.adr, RLSE_IDX_RLS3)) begin
        st_next.dat = {24'h0, e1 ? st_reg.e1_r3 : st_reg.t1_r3};
        if (!wb_req_i.we) begin
          if (e1) begin
            e1_clr = st_reg.e1_r3;
          end else begin
            t1_clr = st_reg.t1_r3;
          end
        end
      end else if (hit(wb_req_i.adr, RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS)) begin
        st_next.dat = {24'h0, st_reg.r4};
        if (!wb_req_i.we) begin
          r4_clr = st_reg.r4;
        end
      end else if (hit(wb_req_i.adr, RLSE_IDX_CTRL)) begin
        st_next.dat = {24'h0, st_reg.ctrl};
        if (wb_req_i.we && wb_req_i.sel[0]) begin
          st_next.ctrl = wb_req_i.dat[7:0];
        end
      end else if (hit(wb_req_i.adr, RLSE_IDX_SIGEN)) begin
        st_next.dat = st_reg.sig_en;
        for (int b = 0; b < 4; b++) begin
          if (wb_req_i.we && wb_req_i.sel[b]) begin
            st_next.sig_en[8*b +: 8] = wb_req_i.dat[8*b +: 8];
          end
        end
      end
    end

    st_next.t1_r3 = (st_reg.t1_r3 & ~t1_clr) | t1_set;
    st_next.e1_r3 = (st_reg.e1_r3 & ~e1_clr) | e1_set;
    st_next.r4    = (st_reg.r4 & ~r4_clr) | r4_set;
    st_next.e1_r2 = e1_r2_set;
    st_next.pend  = |{st_next.t1_r3, st_next.e1_r3, st_next.r4};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.ctrl <= RLSE_CTRL_RESET;
      st_reg.r4   <= RLSE_LATCH_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // The E1 alignment and timeslot 16 events leave as one-cycle pulses for
  // the neighbouring latched register, which is kept outside this block.
  assign wb_ack_o          = st_reg.ack;
  assign wb_dat_o          = st_reg.dat;
  assign latched_pending_o = st_reg.pend;
  assign e1_event_o        = st_reg.e1_r2;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_bad_word;
    rx_i.fas_word_err & ~rx_i.fas_word_ok;
  endsequence

  a_fas_three_bad: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.ctrl[RLSE_CTRL_E1] & st_reg.fas_cnt == 2'd2 ##0 s_bad_word
    |=> e1_event_o[4])
    else $error("FAS resync event missing after third bad word.");

  a_cas_two_bad: assert property (@(posedge clk_i) disable iff (rst_i)
    e1_event_o[5] |-> $past(st_reg.cas_cnt) == 2'd1)
    else $error("CAS resync event without two bad words.");

  a_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    req & ~wb_req_i.we & hit(wb_req_i.adr, RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS) & ~|r4_set
    ##1 wb_ack_o |-> st_reg.r4 == 8'h00)
    else $error("Buffer status not cleared by read.");

  a_bit_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.r4[R4_SLIP] & ~(req & ~wb_req_i.we) |=> st_reg.r4[R4_SLIP])
    else $error("Slip bit dropped without a read.");

  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_i.elastic_full |=> st_reg.r4[R4_FULL] & st_reg.r4[R4_SLIP])
    else $error("Elastic full event lost.");

  a_clock_loss: assert property (@(posedge clk_i) disable iff (rst_i)
    ~st_reg.ctrl[RLSE_CTRL_E1] & ~st_reg.receive_clock_lost
    & st_reg.idle_cnt == RECEIVE_CLOCK_LOST_T1 & ~edge_r |=> st_reg.receive_clock_lost)
    else $error("Clock loss not flagged after one channel time.");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> ~wb_ack_o)
    else $error("Acknowledge held longer than one cycle.");

  a_scos_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_reg.r4[R4_SCOS])
    |-> $past(|(rx_i.signaling_change & st_reg.sig_en)))
    else $error("Signaling change latched for disabled channel.");

  a_loop_up_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    ~st_reg.ctrl[RLSE_CTRL_E1] & ~st_next.ctrl[RLSE_CTRL_E1]
    & $rose(rx_i.loop_up_present) |=> st_reg.t1_r3[T1_LOOP_UP_DETECTED])
    else $error("Loop-up rising edge not latched.");

endmodule
`default_nettype wire

// [tb/rlse_rx_model.sv]
// Behavioural receive framer, code detectors and elastic store for one port.
// Assumes its tasks are called just after a rising edge of clk_i.
`default_nettype none
module rlse_rx_model
  import rlse_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rclk_run_i,
  output var  rlse_rx_in_t rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg;

  initial begin
    rx_o = '0;
    div_reg = 2'h0;
  end

  // Line clock at a quarter of clk_i; halting it models a dead line.
  always @(posedge clk_i) begin
    if (rclk_run_i) begin
      div_reg <= div_reg + 2'h1;
      rx_o.recovered_receive_clock <= div_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic strobe(input int code, input int n);
    repeat (n) begin
      case (code)
        0: rx_o.elastic_full <= 1'b1;
        1: rx_o.elastic_empty <= 1'b1;
        2: rx_o.cas_word_err <= 1'b1;
        3: rx_o.fas_word_err <= 1'b1;
        5: rx_o.crc_mf_boundary <= 1'b1;
        6: rx_o.cas_word_ok <= 1'b1;
        default: rx_o.rx_mf_boundary <= 1'b1;
      endcase
      @(posedge clk_i);
      rx_o.crc_mf_boundary <= 1'b0;
      rx_o.cas_word_ok <= 1'b0;
      rx_o.elastic_full <= 1'b0;
      rx_o.elastic_empty <= 1'b0;
      rx_o.cas_word_err <= 1'b0;
      rx_o.fas_word_err <= 1'b0;
      rx_o.rx_mf_boundary <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic level(input int code, input logic v);
    case (code)
      0: rx_o.loop_up_present <= v;
      1: rx_o.loop_down_present <= v;
      2: rx_o.spare_code_present <= v;
      default: rx_o.v52_link_present <= v;
    endcase
    repeat (3) @(posedge clk_i);
  endtask

  task automatic sig(input logic [31:0] m);
    rx_o.signaling_change <= m;
    @(posedge clk_i);
    rx_o.signaling_change <= 32'h0000_0000;
    @(posedge clk_i);
  endtask

  // Between frames the slot byte is inverted so stale data is never reused.
  task automatic mf(input logic [7:0] ts0, input logic [7:0] ts);
    for (int f = 0; f < 16; f++) begin
      rx_o.frame <= 1'b1;
      rx_o.cas_mf_start <= (f == 0);
      rx_o.ts16 <= (f == 0) ? ts0 : ts;
      @(posedge clk_i);
      rx_o.frame <= 1'b0;
      rx_o.cas_mf_start <= 1'b0;
      rx_o.ts16 <= ~rx_o.ts16;
      @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [tb/rlse_port_tb.sv]
// Self-checking bench of the receive latched status block at port 10.
// Assumes rlse_rx_model feeds rx_i; timers are shortened by parameters.
`default_nettype none
module rlse_port_tb
  import rlse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PORT  = 10;
  localparam int PBASE = 32'h200 * (PORT - 1) + 32'h2000 * ((PORT - 1) / 8);
  logic         clk_i        = 1'b0;
  logic         rst_i        = 1'b1;
  logic         rclk_run     = 1'b1;
  logic         ev_clr       = 1'b0;
  logic [7:0]   ev_seen      = 8'h00;
  logic [31:0]  rd;
  int           err_count    = 0;
  int           total_checks = 0;
  rlse_wb_req_t wb_req       = '0;
  rlse_rx_in_t  rx;
  logic         wb_ack;
  logic [31:0]  wb_dat;
  logic         pending;
  logic [7:0]   e1_event;

  always #2 clk_i = ~clk_i;

  // Only the intervals that a scenario judges are shortened; the E1 second,
  // E1 short interval and T1 align interval keep their full lengths.
  rlse_port #(
    .PORT_NUM(PORT), .SEC_T1(40), .SHORT_T1(20), .CRCMF_EDGES(16),
    .AF_EDGES_E1(8)
  ) u_rlse_port (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack),
    .wb_dat_o(wb_dat), .rx_i(rx), .latched_pending_o(pending),
    .e1_event_o(e1_event)
  );

  rlse_rx_model u_rx (.clk_i(clk_i), .rclk_run_i(rclk_run), .rx_o(rx));

  always @(posedge clk_i) begin
    if (ev_clr) begin
      ev_seen <= 8'h00;
    end else begin
      ev_seen <= ev_seen | e1_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [17:0] ra(input logic [15:0] idx);
    return 18'((PBASE + idx) * 4);
  endfunction

  task automatic wb(input logic we, input logic [17:0] adr,
                    input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    rd = wb_dat;
    wb_req <= '0;
    if (wb_ack !== 1'b1) chk("ack", 32'h1, 32'h0);
  endtask

  task automatic rdc(input string nm, input logic [15:0] idx,
                     input logic [7:0] m, input logic [7:0] exp);
    wb(1'b0, ra(idx), 32'h0);
    chk(nm, {24'h0, exp}, rd & {24'h0, m});
  endtask

  task automatic evc(input string nm, input int b, input logic v);
    repeat (3) @(posedge clk_i);
    chk(nm, 32'(v), 32'(ev_seen[b]));
  endtask

  task automatic evclr();
    ev_clr <= 1'b1;
    @(posedge clk_i);
    ev_clr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("pending_rst", 32'h0, 32'(pending));
    rdc("rls3_rst", RLSE_IDX_RLS3, 8'hFF, 8'h00);
    rdc("buffer_signaling_timer_latched_status_rst", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'hE8, 8'h00);
  endtask

  task automatic t_elastic();
    u_rx.strobe(0, 1);
    chk("pending_set", 32'h1, 32'(pending));
    rdc("full", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'hE8, 8'hA0);
    rdc("full_read", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'hE8, 8'h00);
    u_rx.strobe(1, 1);
    rdc("empty", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'hE8, 8'h60);
    u_rx.strobe(0, 1);
    wb(1'b0, 18'(RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS * 4), 32'h0);
    chk("other_port", 32'h0, rd);
    fork
      begin
        @(posedge clk_i);
        u_rx.strobe(0, 1);
      end
      wb(1'b0, ra(RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS), 32'h0);
    join
    rdc("overlap", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'hE8, 8'hA0);
  endtask

  task automatic t_codes();
    for (int i = 0; i < 3; i++) begin
      u_rx.level(i, 1'b1);
      rdc("code_on", RLSE_IDX_RLS3, 8'h77, 8'(1 << i));
      u_rx.level(i, 1'b0);
      rdc("code_off", RLSE_IDX_RLS3, 8'h77, 8'(16 << i));
    end
  endtask

  // The loss threshold is one channel time, about 1295 clocks in T1 mode.
  task automatic t_receive_clock_lost();
    rclk_run <= 1'b0;
    repeat (1200) @(posedge clk_i);
    rdc("receive_clock_lost_early", RLSE_IDX_RLS3, 8'h88, 8'h00);
    repeat (200) @(posedge clk_i);
    rdc("receive_clock_lost_on", RLSE_IDX_RLS3, 8'h88, 8'h08);
    rclk_run <= 1'b1;
    repeat (12) @(posedge clk_i);
    rdc("receive_clock_lost_off", RLSE_IDX_RLS3, 8'h88, 8'h80);
  endtask

  task automatic t_sig_timer();
    wb(1'b1, ra(RLSE_IDX_SIGEN), 32'h0000_0002);
    u_rx.sig(32'h0000_0001);
    rdc("sig_off", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h08, 8'h00);
    u_rx.sig(32'h0000_0002);
    rdc("sig_on", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h08, 8'h08);
    wb(1'b1, ra(RLSE_IDX_CTRL), 32'h0000_0008);
    wb(1'b0, ra(RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS), 32'h0);
    repeat (200) @(posedge clk_i);
    rdc("sec_manual", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h06, 8'h04);
    wb(1'b1, ra(RLSE_IDX_CTRL), 32'h0000_0018);
    rdc("manual", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h02, 8'h02);
    wb(1'b1, ra(RLSE_IDX_CTRL), 32'h0000_0000);
    repeat (200) @(posedge clk_i);
    rdc("timer_sec", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h02, 8'h02);
    // Three windows a little longer than the short interval; the long
    // interval cannot land in all three of them.
    wb(1'b1, ra(RLSE_IDX_CTRL), 32'h0000_0004);
    wb(1'b0, ra(RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS), 32'h0);
    repeat (3) begin
      repeat (100) @(posedge clk_i);
      rdc("timer_short", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h02, 8'h02);
    end
    u_rx.strobe(4, 1);
    rdc("rmf", RLSE_IDX_BUFFER_SIGNALING_TIMER_LATCHED_STATUS, 8'h01, 8'h01);
  endtask

  task automatic t_e1();
    wb(1'b1, ra(RLSE_IDX_CTRL), 32'h0000_0001);
    evclr();
    u_rx.strobe(2, 1);
    evc("cas_one", 5, 1'b0);
    u_rx.strobe(2, 1);
    evc("cas_two", 5, 1'b1);
    u_rx.strobe(3, 2);
    evc("fas_two", 4, 1'b0);
    u_rx.strobe(3, 1);
    evc("fas_three", 4, 1'b1);
    evclr();
    u_rx.strobe(2, 1);
    u_rx.strobe(6, 1);
    u_rx.strobe(2, 1);
    evc("cas_broken", 5, 1'b0);
    u_rx.level(3, 1'b1);
    rdc("v52_on", RLSE_IDX_RLS3, 8'h22, 8'h02);
    u_rx.level(3, 1'b0);
    rdc("v52_off", RLSE_IDX_RLS3, 8'h22, 8'h20);
    repeat (3) u_rx.mf(8'hFF, 8'hFF);
    evc("ts16_ones", 3, 1'b1);
    evc("no_zeros", 2, 1'b0);
    rdc("dma_on", RLSE_IDX_RLS3, 8'h11, 8'h01);
    repeat (3) u_rx.mf(8'h00, 8'h00);
    evc("ts16_zeros", 2, 1'b1);
    rdc("dma_off", RLSE_IDX_RLS3, 8'h11, 8'h10);
    evc("crc_mf", 1, 1'b1);
    evc("align", 0, 1'b1);
    wb(1'b1, ra(RLSE_IDX_CTRL), 32'h0000_0003);
    evclr();
    repeat (100) @(posedge clk_i);
    chk("crc_quiet", 32'h0, 32'(ev_seen[1]));
    u_rx.strobe(5, 1);
    evc("crc_on", 1, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole sequence needs a few thousand cycles; allow several times that.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_elastic();
    t_codes();
    t_receive_clock_lost();
    t_sig_timer();
    t_e1();
    stop_test();
  end
endmodule
`default_nettype wire
